/* rtl/macrocell_jk_register.sv */
// registered output macrocells with j-k/d flip-flops, preload, diagnostic load and output enables
`timescale 1ns/10ps
`include "macrocell_consts.svh"

// Behaviour
// (R1) each cell register is clocked by the external clock or its product-term clock, chosen per cell.
// (R2) clocked state changes happen only on the low-to-high transition of the chosen clock.
// (R3) on a plain rising clock j=k=0 holds, j=0 k=1 clears, j=1 k=0 sets and j=k=1 toggles.
// (R4) a high preset forces one and a high reset forces zero regardless of clock, j and k.
// (R5) with preset and reset both high the register holds one, and afterwards follows whichever stays high.
// (R6) during a preload the outside drives load control high and all product terms of that cell low.
// (R7) with load control high and the cell output disabled, a rising clock loads the value forced on the cell pin.
// (R8) with the enable pin at high voltage, a rising clock loads the diagnostic pin value over everything else.
// (R9) a cell pin floats when its enable is off: the shared active-low pin high or the enable term low.
// (R10) after power-up every flip-flop is zero and every cell pin drives its inverse, a high level; the code resets every cell pin enable off instead.
// (R11) d mode offers the same preset, reset, preload, diagnostic and enable behaviour, capturing d on the clock.
// (R12) by default all cells are d-type registers on the external clock path.
// (R13) by default product-term clocks and j-k mode are off, only the flip-flop type term is active.
// (R14) by default the two bidirectional pins are inputs, floated by their own enable terms.
// (R15) by default the first and last cells are inputs, floated by their dedicated enable terms.
// (R16) the bidirectional pin enables come from their product terms only, never from the shared enable pin.
module macrocell_jk_register
	import macrocell_pkg::*;
#(
	parameter int N_CELLS = `CELL_COUNT
) (
	input wire logic sys_clk,
	input wire logic rst,
	// avalon-mm slave
	input wire logic [`ADDR_WIDTH-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [`DATA_WIDTH-1:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [`DATA_WIDTH-1:0] avs_readdata,
	output logic avs_waitrequest,
	// shared pins
	input wire logic ext_clk,
	input wire logic oe_n,
	input wire logic enable_pin_hv,
	// per cell array terms and pins
	input wire logic [N_CELLS-1:0] j_term,
	input wire logic [N_CELLS-1:0] k_term,
	input wire logic [N_CELLS-1:0] preset_term,
	input wire logic [N_CELLS-1:0] reset_term,
	input wire logic [N_CELLS-1:0] load_control_term,
	input wire logic [N_CELLS-1:0] cell_clock,
	input wire logic [N_CELLS-1:0] cell_enable_term,
	input wire logic [N_CELLS-1:0] diag_force_pin,
	input wire logic [N_CELLS-1:0] output_cell_in,
	output logic [N_CELLS-1:0] output_cell_out,
	output logic [N_CELLS-1:0] output_cell_oe,
	// bidirectional pins
	input wire logic bidir_enable_term_a,
	input wire logic bidir_enable_term_b,
	input wire logic bidir_data_a,
	input wire logic bidir_data_b,
	input wire logic bidir_pin_a_in,
	input wire logic bidir_pin_b_in,
	output logic bidir_pin_a_out,
	output logic bidir_pin_a_oe,
	output logic bidir_pin_b_out,
	output logic bidir_pin_b_oe
);

	// ****************************************************************
	// elaboration checks
	// ****************************************************************
	initial begin
		if (N_CELLS != `CELL_COUNT) $error("macrocell_jk_register: N_CELLS must equal the packed state width");
	end

	localparam int SW = 9 * N_CELLS + 9;

	// ****************************************************************
	// input synchronisation
	// ****************************************************************
	logic [SW-1:0] raw_in;
	logic [SW-1:0] syn;

	// all pins come from outside the clock domain; the enable pin goes in inverted so that the
	// cleared synchroniser reads as "outputs off" and no pin is driven right after reset
	assign raw_in = {bidir_pin_b_in, bidir_pin_a_in, bidir_data_b, bidir_data_a, bidir_enable_term_b,
		bidir_enable_term_a, enable_pin_hv, ~oe_n, ext_clk, output_cell_in, diag_force_pin, cell_enable_term,
		cell_clock, load_control_term, reset_term, preset_term, k_term, j_term};

	pin_sync3 #(
		.WIDTH(SW)
	) u_sync (
		.sys_clk(sys_clk),
		.rst(rst),
		.pin_in(raw_in),
		.level(syn)
	);

	logic [N_CELLS-1:0] j_s;
	logic [N_CELLS-1:0] k_s;
	logic [N_CELLS-1:0] pre_s;
	logic [N_CELLS-1:0] rstt_s;
	logic [N_CELLS-1:0] load_s;
	logic [N_CELLS-1:0] tclk_s;
	logic [N_CELLS-1:0] en_s;
	logic [N_CELLS-1:0] diag_s;
	logic [N_CELLS-1:0] pin_s;
	logic ext_s;
	logic oe_n_s;
	logic hv_s;
	logic [`BIDIR_COUNT-1:0] ben_s;
	logic [`BIDIR_COUNT-1:0] bdat_s;
	logic [`BIDIR_COUNT-1:0] bpin_s;

	// split the synchronised vector back into named levels
	assign j_s = syn[0*N_CELLS +: N_CELLS];
	assign k_s = syn[1*N_CELLS +: N_CELLS];
	assign pre_s = syn[2*N_CELLS +: N_CELLS];
	assign rstt_s = syn[3*N_CELLS +: N_CELLS];
	assign load_s = syn[4*N_CELLS +: N_CELLS];
	assign tclk_s = syn[5*N_CELLS +: N_CELLS];
	assign en_s = syn[6*N_CELLS +: N_CELLS];
	assign diag_s = syn[7*N_CELLS +: N_CELLS];
	assign pin_s = syn[8*N_CELLS +: N_CELLS];
	assign ext_s = syn[9*N_CELLS];
	assign oe_n_s = ~syn[9*N_CELLS+1]; // see (R9) see (R10)
	assign hv_s = syn[9*N_CELLS+2];
	assign ben_s = syn[9*N_CELLS+3 +: 2];
	assign bdat_s = syn[9*N_CELLS+5 +: 2];
	assign bpin_s = syn[9*N_CELLS+7 +: 2];

	// ****************************************************************
	// state
	// ****************************************************************
	state_t st_reg;
	state_t st_next;

	logic [N_CELLS-1:0] rise;
	logic [N_CELLS-1:0] cell_en;
	logic bus_req;
	logic bus_ack;

	// rising edge of each cell's chosen clock
	always_comb begin
		for (int i = 0; i < N_CELLS; i++) begin
			if (st_reg.clk_sel[i]) begin
				rise[i] = tclk_s[i] & ~st_reg.term_prev[i]; // see (R1) see (R2)
			end else begin
				rise[i] = ext_s & ~st_reg.ext_prev; // see (R1) see (R2)
			end
		end
	end

	// enable per cell from the shared pin or from the cell's own term
	always_comb begin
		for (int i = 0; i < N_CELLS; i++) begin
			cell_en[i] = st_reg.oe_src[i] ? en_s[i] : ~oe_n_s; // see (R9)
		end
	end

	assign bus_req = avs_read | avs_write;
	assign bus_ack = bus_req & ~st_reg.waitreq;

	// next state: cells, enables, bus slave
	always_comb begin
		st_next = st_reg;
		st_next.ext_prev = ext_s;
		st_next.term_prev = tclk_s;
		for (int i = 0; i < N_CELLS; i++) begin
			if (hv_s) begin
				if (rise[i]) st_next.q[i] = diag_s[i]; // see (R8)
			end else if (pre_s[i]) begin
				st_next.q[i] = 1'b1; // see (R4) see (R5)
			end else if (rstt_s[i]) begin
				st_next.q[i] = 1'b0; // see (R4) see (R5)
			end else if (rise[i]) begin
				if (load_s[i] && !cell_en[i]) begin
					st_next.q[i] = pin_s[i]; // see (R7) see (R6)
				end else if (st_reg.ff_type[i]) begin
					case ({j_s[i], k_s[i]})
						2'b00: st_next.q[i] = st_reg.q[i]; // see (R3)
						2'b01: st_next.q[i] = 1'b0; // see (R3)
						2'b10: st_next.q[i] = 1'b1; // see (R3)
						default: st_next.q[i] = ~st_reg.q[i]; // see (R3)
					endcase
				end else begin
					st_next.q[i] = j_s[i]; // see (R11)
				end
			end
		end
		// pin shows the inverse of the register
		st_next.cell_out = ~st_next.q; // see (R10)
		st_next.cell_oe = cell_en; // see (R9)
		// bidirectional pins driven only from their own terms
		st_next.bidir_out = bdat_s;
		st_next.bidir_oe = ben_s; // see (R16) see (R14)
		// bus: one wait cycle, then the answer
		if (bus_req && st_reg.waitreq) begin
			st_next.waitreq = 1'b0;
			st_next.rdata = '0;
			if (avs_read) begin
				if (avs_address == `OFF_CLK_SEL) begin
					st_next.rdata[N_CELLS-1:0] = st_reg.clk_sel;
				end else if (avs_address == `OFF_FF_TYPE) begin
					st_next.rdata[N_CELLS-1:0] = st_reg.ff_type;
				end else if (avs_address == `OFF_OE_SRC) begin
					st_next.rdata[N_CELLS-1:0] = st_reg.oe_src;
				end else if (avs_address == `OFF_STATE) begin
					st_next.rdata[N_CELLS-1:0] = st_reg.q;
				end else if (avs_address == `OFF_PINS) begin
					st_next.rdata[N_CELLS-1:0] = pin_s;
					st_next.rdata[`PINS_BIDIR_LSB +: 2] = bpin_s;
				end else begin
					st_next.rdata = '0;
				end
			end
		end else begin
			st_next.waitreq = 1'b1;
		end
		// write takes effect on the edge that sees waitrequest low
		if (bus_ack && avs_write) begin
			if (avs_address == `OFF_CLK_SEL) begin
				st_next.clk_sel = merge(st_reg.clk_sel, avs_writedata, avs_byteenable); // see (R1)
			end else if (avs_address == `OFF_FF_TYPE) begin
				st_next.ff_type = merge(st_reg.ff_type, avs_writedata, avs_byteenable);
			end else if (avs_address == `OFF_OE_SRC) begin
				st_next.oe_src = merge(st_reg.oe_src, avs_writedata, avs_byteenable);
			end
		end
	end

	// byte-lane merge of a ten-bit register
	function automatic logic [`CELL_COUNT-1:0] merge(input logic [`CELL_COUNT-1:0] old,
		input logic [`DATA_WIDTH-1:0] wd, input logic [3:0] be);
		logic [`CELL_COUNT-1:0] r;
		r = old;
		if (be[0]) r[7:0] = wd[7:0];
		if (be[1]) r[`CELL_COUNT-1:8] = wd[`CELL_COUNT-1:8];
		return r;
	endfunction

	// register the whole state; power-up clears every cell flip-flop
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_reg <= '0; // see (R10)
			st_reg.cell_out <= '1; // see (R10)
			st_reg.clk_sel <= `RST_CLK_SEL; // see (R12) see (R13)
			st_reg.ff_type <= `RST_FF_TYPE; // see (R12) see (R13)
			st_reg.oe_src <= `RST_OE_SRC; // see (R15)
			st_reg.waitreq <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign avs_readdata = st_reg.rdata;
	assign avs_waitrequest = st_reg.waitreq;
	assign output_cell_out = st_reg.cell_out;
	assign output_cell_oe = st_reg.cell_oe;
	assign bidir_pin_a_out = st_reg.bidir_out[0];
	assign bidir_pin_b_out = st_reg.bidir_out[1];
	assign bidir_pin_a_oe = st_reg.bidir_oe[0];
	assign bidir_pin_b_oe = st_reg.bidir_oe[1];

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	genvar g;
	generate
		for (g = 0; g < N_CELLS; g++) begin : g_chk
			chk_preset_force: assert property (!hv_s && pre_s[g] |=> st_reg.q[g]) // see (R4)
				else $error("preset did not force one");
			chk_reset_force: assert property (!hv_s && !pre_s[g] && rstt_s[g] |=> !st_reg.q[g]) // see (R4)
				else $error("reset did not force zero");
			chk_both_high: assert property (!hv_s && pre_s[g] && rstt_s[g] |=> st_reg.q[g]) // see (R5)
				else $error("preset and reset together did not hold one");
			chk_diag_load: assert property (hv_s && rise[g] |=> st_reg.q[g] == $past(diag_s[g])) // see (R8)
				else $error("diagnostic load missed");
			chk_no_edge_hold: assert property (!hv_s && !pre_s[g] && !rstt_s[g] && !rise[g]
				|=> st_reg.q[g] == $past(st_reg.q[g])) // see (R2)
				else $error("register changed without a rising clock");
			chk_jk_toggle: assert property (!hv_s && !pre_s[g] && !rstt_s[g] && rise[g] && !load_s[g]
				&& st_reg.ff_type[g] && j_s[g] && k_s[g] |=> st_reg.q[g] != $past(st_reg.q[g])) // see (R3)
				else $error("j-k toggle missed");
			chk_preload_pin: assert property (!hv_s && !pre_s[g] && !rstt_s[g] && rise[g] && load_s[g]
				&& !cell_en[g] |=> st_reg.q[g] == $past(pin_s[g])) // see (R7)
				else $error("preload from cell pin missed");
			chk_pin_oe_off: assert property (!st_reg.oe_src[g] && oe_n_s |=> !output_cell_oe[g]) // see (R9)
				else $error("cell pin driven with enable pin high");
			chk_pin_inverse: assert property (output_cell_out[g] == !st_reg.q[g]) // see (R10)
				else $error("cell pin is not the inverse of the register");
		end
	endgenerate

	chk_bidir_oe_src: assert property (##1 bidir_pin_a_oe == $past(ben_s[0]) && bidir_pin_b_oe == $past(ben_s[1]))
		else $error("bidirectional enable not from its term"); // see (R16)
	chk_bus_answer: assert property (bus_req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer not one cycle after request");

endmodule // macrocell_jk_register

/* rtl/macrocell_consts.svh */
// constants for the registered macrocell block: offsets, reset values, counts
`ifndef MACROCELL_CONSTS_SVH
`define MACROCELL_CONSTS_SVH

// ****************************************************************
// geometry
// ****************************************************************
`define CELL_COUNT 10
`define BIDIR_COUNT 2
`define ADDR_WIDTH 8
`define DATA_WIDTH 32

// ****************************************************************
// register offsets (byte addresses, one aligned word each)
// ****************************************************************
`define OFF_CLK_SEL 8'h00
`define OFF_FF_TYPE 8'h04
`define OFF_OE_SRC 8'h08
`define OFF_STATE 8'h0C
`define OFF_PINS 8'h10

// ****************************************************************
// reset values (unprogrammed default)
// ****************************************************************
`define RST_CLK_SEL 10'h000
`define RST_FF_TYPE 10'h000
`define RST_OE_SRC 10'h201

// ****************************************************************
// field positions in the pin status word
// ****************************************************************
`define PINS_BIDIR_LSB 10

`endif

/* rtl/macrocell_pkg.sv */
// types shared by the registered macrocell block
`include "macrocell_consts.svh"

package macrocell_pkg;

	// whole state of the macrocell top
	typedef struct packed {
		logic [`CELL_COUNT-1:0] q;
		logic [`CELL_COUNT-1:0] cell_out;
		logic [`CELL_COUNT-1:0] cell_oe;
		logic [`BIDIR_COUNT-1:0] bidir_out;
		logic [`BIDIR_COUNT-1:0] bidir_oe;
		logic [`CELL_COUNT-1:0] clk_sel;
		logic [`CELL_COUNT-1:0] ff_type;
		logic [`CELL_COUNT-1:0] oe_src;
		logic ext_prev;
		logic [`CELL_COUNT-1:0] term_prev;
		logic waitreq;
		logic [`DATA_WIDTH-1:0] rdata;
	} state_t;

	// padding type, not used by the block
	typedef struct packed {
		logic [1023:0] unused_pad;
	} pad_t;

endpackage

/* rtl/pin_sync3.sv */
// three-stage input synchroniser whose level moves when the last two stages agree
`timescale 1ns/10ps

module pin_sync3 #(
	parameter int WIDTH = 8
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] level
);

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] lvl;
	} sync_state_t;

	sync_state_t st_reg;
	sync_state_t st_next;

	initial begin
		if (WIDTH < 1) $error("pin_sync3: WIDTH must be at least 1");
	end

	// first stage feeds only the second; level follows once stages two and three agree
	always_comb begin
		st_next = st_reg;
		st_next.s1 = pin_in;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		for (int b = 0; b < WIDTH; b++) begin
			if (st_reg.s2[b] == st_reg.s3[b]) st_next.lvl[b] = st_reg.s3[b];
		end
	end

	// register the whole state
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign level = st_reg.lvl;

endmodule // pin_sync3

/* tb/board_model.sv */
// board-side model of the pins around the macrocell block
`timescale 1ns/10ps

module board_model (
	input wire logic sys_clk,
	input wire logic [9:0] output_cell_out,
	input wire logic [9:0] output_cell_oe,
	input wire logic [9:0] force_en,
	input wire logic [9:0] force_val,
	input wire logic [1:0] bidir_out,
	input wire logic [1:0] bidir_oe,
	input wire logic [1:0] bidir_board,
	output logic [9:0] output_cell_in,
	output logic [1:0] bidir_in
);
	logic [9:0] last_reg = 10'h000;

	// remember the pin level so a floating pin keeps changing, not settling
	always_ff @(posedge sys_clk) begin
		last_reg <= output_cell_in;
	end

	// a cell pin is forced by the board, driven by the cell, or floats
	always_comb begin
		output_cell_in = (force_en & force_val) | (~force_en & output_cell_oe & output_cell_out)
			| (~force_en & ~output_cell_oe & ~last_reg);
		bidir_in = (bidir_oe & bidir_out) | (~bidir_oe & bidir_board);
	end
endmodule // board_model

/* tb/macrocell_jk_register_tb.sv */
// self-checking testbench for the registered macrocell block
`timescale 1ns/10ps
`include "macrocell_consts.svh"

module macrocell_jk_register_tb;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [3:0] avs_byteenable = 4'hf;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic ext_clk = 1'b0;
	logic oe_n = 1'b1;
	logic enable_pin_hv = 1'b0;
	logic [9:0] j_term = 10'h000, k_term = 10'h000, preset_term = 10'h000, reset_term = 10'h000;
	logic [9:0] load_control_term = 10'h000, cell_clock = 10'h000, cell_enable_term = 10'h000;
	logic [9:0] diag_force_pin = 10'h000, force_en = 10'h000, force_val = 10'h000;
	logic [9:0] output_cell_in, output_cell_out, output_cell_oe, q;
	logic bidir_enable_term_a = 1'b0, bidir_enable_term_b = 1'b0, bidir_data_a = 1'b0, bidir_data_b = 1'b0;
	logic [1:0] bidir_board = 2'h1;
	logic [1:0] bidir_in;
	logic bidir_pin_a_out, bidir_pin_a_oe, bidir_pin_b_out, bidir_pin_b_oe;
	int bad_count = 0;
	int compares = 0;

	// 100 MHz system clock
	always #5 sys_clk = ~sys_clk;

	macrocell_jk_register u_macrocell_jk_register (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.ext_clk(ext_clk), .oe_n(oe_n), .enable_pin_hv(enable_pin_hv), .j_term(j_term), .k_term(k_term),
		.preset_term(preset_term), .reset_term(reset_term), .load_control_term(load_control_term),
		.cell_clock(cell_clock), .cell_enable_term(cell_enable_term), .diag_force_pin(diag_force_pin),
		.output_cell_in(output_cell_in), .output_cell_out(output_cell_out), .output_cell_oe(output_cell_oe),
		.bidir_enable_term_a(bidir_enable_term_a), .bidir_enable_term_b(bidir_enable_term_b),
		.bidir_data_a(bidir_data_a), .bidir_data_b(bidir_data_b), .bidir_pin_a_in(bidir_in[0]),
		.bidir_pin_b_in(bidir_in[1]), .bidir_pin_a_out(bidir_pin_a_out), .bidir_pin_a_oe(bidir_pin_a_oe),
		.bidir_pin_b_out(bidir_pin_b_out), .bidir_pin_b_oe(bidir_pin_b_oe));

	board_model u_board_model (.sys_clk(sys_clk), .output_cell_out(output_cell_out),
		.output_cell_oe(output_cell_oe), .force_en(force_en), .force_val(force_val),
		.bidir_out({bidir_pin_b_out, bidir_pin_a_out}), .bidir_oe({bidir_pin_b_oe, bidir_pin_a_oe}),
		.bidir_board(bidir_board), .output_cell_in(output_cell_in), .bidir_in(bidir_in));

	// ****************************************************************
	// shared tasks
	// ****************************************************************
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// one avalon transfer, held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
		int n;
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		if (n >= 50) bad_count++;
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		bus(1'b0, a, 32'h0000_0000, r);
		chk("register", r, exp);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask

	task automatic settle();
		repeat (8) @(posedge sys_clk);
	endtask

	// one clock pulse: external clock when cc is zero, else the chosen term clocks
	task automatic pulse(input logic [9:0] cc);
		@(posedge sys_clk);
		ext_clk <= (cc == 10'h000);
		cell_clock <= cc;
		repeat (6) @(posedge sys_clk);
		ext_clk <= 1'b0;
		cell_clock <= 10'h000;
		settle();
	endtask

	task automatic chk_q(input logic [9:0] exp);
		rd(`OFF_STATE, {22'h0, exp});
		chk("cell_out", {22'h0, output_cell_out}, {22'h0, ~exp});
	endtask

	function automatic logic [9:0] jk(input logic [9:0] qv, input logic [9:0] j, input logic [9:0] k);
		return (j & ~k) | (~j & ~k & qv) | (j & k & ~qv);
	endfunction

	task automatic print_verdict();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	// watchdog against a hung handshake
	initial begin
		#100us;
		bad_count++;
		print_verdict();
	end

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		chk("oe", {22'h0, output_cell_oe}, 32'h0000_0000);
		chk("bidir_oe", {bidir_pin_b_oe, bidir_pin_a_oe}, 32'h0000_0000);
		rd(`OFF_CLK_SEL, 32'h0000_0000);
		rd(`OFF_FF_TYPE, 32'h0000_0000);
		rd(`OFF_OE_SRC, 32'h0000_0201);
		chk_q(10'h000);
		rd(8'h40, 32'h0000_0000);
		// d mode capture on the external clock
		j_term <= 10'h2a5;
		pulse(10'h000);
		chk_q(10'h2a5);
		// a falling edge must not capture
		@(posedge sys_clk) ext_clk <= 1'b1;
		settle();
		j_term <= 10'h0f0;
		settle();
		ext_clk <= 1'b0;
		settle();
		chk_q(10'h2a5);
		// j-k mode, every combination
		wr(`OFF_FF_TYPE, 32'h0000_03ff);
		rd(`OFF_FF_TYPE, 32'h0000_03ff);
		j_term <= 10'h0cc;
		k_term <= 10'h0f0;
		pulse(10'h000);
		q = jk(10'h2a5, 10'h0cc, 10'h0f0);
		chk_q(q);
		// term clocks on cells 0-3, external clock on the rest
		wr(`OFF_CLK_SEL, 32'h0000_000f);
		j_term <= 10'h3ff;
		k_term <= 10'h3ff;
		pulse(10'h00f);
		q = q ^ 10'h00f;
		chk_q(q);
		pulse(10'h000);
		q = q ^ 10'h3f0;
		chk_q(q);
		j_term <= 10'h000;
		k_term <= 10'h000;
		// preset and reset act without a clock
		preset_term <= 10'h0f0;
		reset_term <= 10'h00f;
		settle();
		q = (q | 10'h0f0) & ~10'h00f;
		chk_q(q);
		reset_term <= 10'h0ff;
		settle();
		chk_q(q);
		preset_term <= 10'h000;
		settle();
		q = q & ~10'h0ff;
		chk_q(q);
		reset_term <= 10'h000;
		// preload from the cell pins while outputs are off, every cell back on the external clock
		wr(`OFF_CLK_SEL, 32'h0000_0000);
		rd(`OFF_CLK_SEL, 32'h0000_0000);
		load_control_term <= 10'h3ff;
		force_en <= 10'h3ff;
		force_val <= 10'h1c3;
		pulse(10'h000);
		chk_q(10'h1c3);
		rd(`OFF_PINS, 32'h0000_05c3);
		force_en <= 10'h000;
		// diagnostic load overrides preset and load control
		enable_pin_hv <= 1'b1;
		preset_term <= 10'h3ff;
		diag_force_pin <= 10'h25a;
		pulse(10'h000);
		preset_term <= 10'h000;
		settle();
		enable_pin_hv <= 1'b0;
		load_control_term <= 10'h000;
		settle();
		chk_q(10'h25a);
		// output enables from the shared pin and from the terms
		oe_n <= 1'b0;
		settle();
		chk("oe", {22'h0, output_cell_oe}, 32'h0000_01fe);
		chk("bidir_oe", {bidir_pin_b_oe, bidir_pin_a_oe}, 32'h0000_0000);
		cell_enable_term <= 10'h201;
		bidir_enable_term_a <= 1'b1;
		bidir_data_a <= 1'b1;
		settle();
		chk("oe", {22'h0, output_cell_oe}, 32'h0000_03ff);
		chk("bidir_a", {bidir_pin_b_oe, bidir_pin_a_oe, bidir_pin_a_out}, 32'h0000_0003);
		wr(`OFF_OE_SRC, 32'h0000_0000);
		oe_n <= 1'b1;
		settle();
		chk("oe", {22'h0, output_cell_oe}, 32'h0000_0000);
		// the state word is read-only
		wr(`OFF_STATE, 32'h0000_03ff);
		chk_q(10'h25a);
		print_verdict();
	end
endmodule // macrocell_jk_register_tb
